//--- hw/embp_pkg.sv
// package for the external memory bus port: constants and request/pin carriers
package embp_pkg;
   localparam int ADDR_W       = 16;
   localparam int DATA_W       = 16;
   localparam int GPIO_HI_W    = 8;
   localparam int GPIO_MID_W   = 2;
   localparam int ADDR_LO_W    = 6;
   // access phase lengths in sys_clk cycles; the strobe is low for the strobe phase only
   localparam int SETUP_CYC    = 1;
   localparam int STROBE_CYC   = 2;
   localparam int HOLD_CYC     = 1;
   localparam int CNT_W        = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

   typedef struct packed {
      logic                 write;
      logic                 prog_space;
      logic [ADDR_W-1:0]    addr;
      logic [DATA_W-1:0]    wdata;
   } embp_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0]    addr;
      logic                 prog_sel_n;
      logic                 data_sel_n;
      logic                 rd_n;
      logic                 wr_n;
   } embp_pins_t;
endpackage

//--- hw/embp_sync2.sv
// two-flop synchroniser, one instance per bit through a generate loop
`timescale 1ns/1ps
module embp_sync2 #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         srst,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_comb
         begin
            meta_next[i] = srst ? 1'b0 : d[i];
            q_next[i]    = srst ? 1'b0 : meta_reg[i];
         end
         always_ff @(posedge sys_clk)
         begin
            meta_reg[i] <= meta_next[i];
            q_reg[i]    <= q_next[i];
         end
      end
   endgenerate

   assign q = q_reg;
endmodule

//--- hw/embp_port.sv
// external memory bus port: strobed read/write master to static memories
`timescale 1ns/1ps
module embp_port
   import embp_pkg::*;
(
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   // request side
   input  wire logic                  req_valid,
   input  wire embp_req_t             req,
   output logic                       req_ready,
   output logic                       rsp_valid,
   output logic      [DATA_W-1:0]     rsp_rdata,
   // pin function select, 1 = gpio
   input  wire logic [GPIO_HI_W-1:0]  upper_address_gpio_port,
   input  wire logic [GPIO_MID_W-1:0] mid_address_gpio_bits,
   // memory pins
   output embp_pins_t                 pins,
   output logic      [ADDR_W-1:0]     ext_address_oe,
   output logic                       ctrl_oe,
   output logic      [DATA_W-1:0]     ext_data_out,
   output logic      [DATA_W-1:0]     ext_data_oe,
   output logic                       ext_data_pullup_en,
   input  wire logic [DATA_W-1:0]     ext_data_in
);
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} embp_state_t;

   embp_state_t          state_reg, state_next;
   logic [CNT_W-1:0]     cnt_reg, cnt_next;
   embp_req_t            cur_reg, cur_next;
   logic [DATA_W-1:0]    rdata_reg, rdata_next;
   logic                 rsp_reg, rsp_next;
   logic                 run_reg, run_next;
   logic [DATA_W-1:0]    data_sync;

   // data pins come from outside the clock domain
   embp_sync2 #(.W(DATA_W)) u_dsync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .d       (ext_data_in),
      .q       (data_sync)
   );

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      cur_next   = cur_reg;
      rdata_next = rdata_reg;
      rsp_next   = 1'b0;
      run_next   = 1'b1;
      case (state_reg)
         ST_IDLE:
         begin
            if (req_valid)
            begin
               cur_next   = req;
               cnt_next   = CNT_W'(SETUP_CYC - 1);
               state_next = ST_SETUP;
            end
         end
         ST_SETUP:
         begin
            // address and selects settle before the strobe falls
            if (cnt_reg == CNT_ZERO)
            begin
               cnt_next   = CNT_W'(STROBE_CYC - 1);
               state_next = ST_STROBE;
            end
            else
               cnt_next = cnt_reg - 4'h1;
         end
         ST_STROBE:
         begin
            if (cnt_reg == CNT_ZERO)
            begin
               cnt_next   = CNT_W'(HOLD_CYC - 1);
               state_next = ST_HOLD;
            end
            else
               cnt_next = cnt_reg - 4'h1;
         end
         ST_HOLD:
         begin
            // address held past the strobe rise so memory latches cleanly
            if (cnt_reg == CNT_ZERO)
            begin
               // two-flop lag: at the end of a one-cycle hold the synchroniser
               // still shows the lines as they stood under the read strobe
               if (!cur_reg.write)
                  rdata_next = data_sync;
               rsp_next   = 1'b1;
               state_next = ST_IDLE;
            end
            else
               cnt_next = cnt_reg - 4'h1;
         end
         default:
            state_next = ST_IDLE;
      endcase
      if (srst)
      begin
         state_next = ST_IDLE;
         cnt_next   = CNT_ZERO;
         cur_next   = '0;
         rdata_next = DATA_RST;
         rsp_next   = 1'b0;
         run_next   = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cur_reg   <= cur_next;
      rdata_reg <= rdata_next;
      rsp_reg   <= rsp_next;
      run_reg   <= run_next;
   end

   logic active;
   logic strobe;
   assign active = (state_reg != ST_IDLE);
   assign strobe = (state_reg == ST_STROBE);

   assign req_ready = (state_reg == ST_IDLE) && run_reg;
   assign rsp_valid = rsp_reg;
   assign rsp_rdata = rdata_reg;

   always_comb
   begin
      pins.addr       = active ? cur_reg.addr : ADDR_RST;
      pins.prog_sel_n = !(active && cur_reg.prog_space);
      pins.data_sel_n = !(active && !cur_reg.prog_space);
      pins.wr_n       = !(strobe && cur_reg.write);
      pins.rd_n       = !(strobe && !cur_reg.write);
   end

   // tristated in reset; upper lines bus by default, gpio only if selected
   always_comb
   begin
      ext_address_oe = {ADDR_W{run_reg}};
      ext_address_oe[ADDR_W-1 -: GPIO_HI_W] =
         {GPIO_HI_W{run_reg}} & ~upper_address_gpio_port;
      ext_address_oe[ADDR_LO_W +: GPIO_MID_W] =
         {GPIO_MID_W{run_reg}} & ~mid_address_gpio_bits;
   end
   assign ctrl_oe = run_reg;

   // data driven only while the write strobe phase lasts
   assign ext_data_out       = cur_reg.wdata;
   assign ext_data_oe        = {DATA_W{strobe && cur_reg.write}};
   assign ext_data_pullup_en = !(strobe && cur_reg.write);

   // write data held valid up to the strobe rise, where memory latches it

   stable_wr_a: assert property (@(posedge sys_clk) disable iff (srst)
      !pins.wr_n && $past(!pins.wr_n) |-> $stable(pins.addr) && $stable(pins.prog_sel_n)
         && $stable(ext_data_out))
      else $error("address or select moved under write strobe");
   stable_rd_a: assert property (@(posedge sys_clk) disable iff (srst)
      !pins.rd_n && $past(!pins.rd_n) |-> $stable(pins.addr) && $stable(pins.data_sel_n))
      else $error("address or select moved under read strobe");
   strobe_excl_a: assert property (@(posedge sys_clk) disable iff (srst)
      !(!pins.rd_n && !pins.wr_n))
      else $error("read and write strobes both low");
   one_select_a: assert property (@(posedge sys_clk) disable iff (srst)
      (!pins.rd_n || !pins.wr_n) |-> (pins.prog_sel_n ^ pins.data_sel_n))
      else $error("not exactly one space select");
   data_release_a: assert property (@(posedge sys_clk) disable iff (srst)
      pins.wr_n |-> ext_data_oe == '0)
      else $error("data driven outside write strobe");
   wr_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
      !pins.wr_n |-> ext_data_oe == '1)
      else $error("data not driven under write strobe");
   strobe_len_a: assert property (@(posedge sys_clk) disable iff (srst)
      $fell(pins.rd_n) |-> !pins.rd_n[*2] ##1 pins.rd_n)
      else $error("read strobe length wrong");
   rd_capture_a: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(pins.rd_n) |=> rsp_valid && rsp_rdata == $past(ext_data_in, 3))
      else $error("read data not captured at strobe rise");
   req_addr_a: assert property (@(posedge sys_clk) disable iff (srst)
      req_valid && req_ready |-> ##2 pins.addr == $past(req.addr, 2))
      else $error("address not presented");
   reset_tri_a: assert property (@(posedge sys_clk)
      $past(srst) |-> ext_address_oe == '0 && !ctrl_oe)
      else $error("address not tristated after reset cycle");
   rst_idle_a: assert property (@(posedge sys_clk)
      srst |=> pins.prog_sel_n && pins.data_sel_n && pins.rd_n && pins.wr_n)
      else $error("strobe or select active after reset");
   rsp_time_a: assert property (@(posedge sys_clk) disable iff (srst)
      req_valid && req_ready |-> ##5 rsp_valid)
      else $error("access answer not at expected cycle");
   idle_release_a: assert property (@(posedge sys_clk) disable iff (srst)
      req_ready |-> pins.rd_n && pins.wr_n && pins.prog_sel_n && pins.data_sel_n)
      else $error("strobe or select active while idle");
   pullup_on_a: assert property (@(posedge sys_clk) disable iff (srst)
      ext_data_oe == '0 |-> ext_data_pullup_en)
      else $error("pull-ups off while data released");
   bus_default_a: assert property (@(posedge sys_clk) disable iff (srst)
      ctrl_oe && upper_address_gpio_port == 8'h00 |-> ext_address_oe[15:8] == 8'hFF)
      else $error("upper address lines not in bus function");

   wr_cov_c: cover property (@(posedge sys_clk) disable iff (srst) $rose(pins.wr_n));
   rd_cov_c: cover property (@(posedge sys_clk) disable iff (srst) $rose(pins.rd_n));
   prog_cov_c: cover property (@(posedge sys_clk) disable iff (srst) !pins.prog_sel_n && !pins.rd_n);
   b2b_cov_c: cover property (@(posedge sys_clk) disable iff (srst) rsp_valid ##2 req_valid && req_ready);
   cut_cov_c: cover property (@(posedge sys_clk) !pins.wr_n ##1 srst);
endmodule

//--- dv/embp_mem_model.sv
// behavioural static memory with program and data spaces on the strobed bus
`timescale 1ns/1ps
module embp_mem_model
   import embp_pkg::*;
(
   // clock
   input  wire logic              sys_clk,
   // bus
   input  wire embp_pins_t        pins,
   input  wire logic [DATA_W-1:0] bus,
   output logic                   mem_oe,
   output logic      [DATA_W-1:0] mem_q
);
   logic [DATA_W-1:0] mem [512];
   logic [DATA_W-1:0] pend;
   logic [8:0]        pend_a;
   logic              wr_q = 1'b1;
   logic [8:0]        idx;
   assign idx    = {~pins.prog_sel_n, pins.addr[7:0]};
   assign mem_oe = ~pins.rd_n & ~(pins.prog_sel_n & pins.data_sel_n);
   assign mem_q  = mem[idx];
   // commit on strobe rise only: data under a falling strobe may not be valid yet
   always @(posedge sys_clk)
   begin
      wr_q <= pins.wr_n;
      if (!pins.wr_n)
      begin
         pend   <= bus;
         pend_a <= idx;
      end
      if (pins.wr_n && !wr_q)
         mem[pend_a] <= pend;
   end
endmodule

//--- dv/embp_port_tb_top.sv
// self-checking bench for the external memory bus port
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin errors++; \
   $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module embp_port_tb_top
   import embp_pkg::*;
;
   logic                  sys_clk = 1'b0;
   logic                  srst = 1'b1;
   logic                  req_valid = 1'b0;
   embp_req_t             req = '0;
   logic                  req_ready;
   logic                  rsp_valid;
   logic [DATA_W-1:0]     rsp_rdata;
   logic [GPIO_HI_W-1:0]  upper_address_gpio_port = 8'h00;
   logic [GPIO_MID_W-1:0] mid_address_gpio_bits = 2'h0;
   embp_pins_t            pins;
   logic [ADDR_W-1:0]     ext_address_oe;
   logic                  ctrl_oe;
   logic [DATA_W-1:0]     ext_data_out;
   logic [DATA_W-1:0]     ext_data_oe;
   logic                  ext_data_pullup_en;
   logic [DATA_W-1:0]     bus;
   logic                  mem_oe;
   logic [DATA_W-1:0]     mem_q;
   logic [ADDR_W-1:0]     exp_aoe = 16'hFFFF;
   int                    errors = 0;
   int                    n_checks = 0;

   always #10 sys_clk = ~sys_clk;
   // pull-ups hold the data lines high whenever nobody drives them
   assign bus = |ext_data_oe ? ext_data_out : mem_oe ? mem_q : ext_data_pullup_en ? 16'hFFFF : ~ext_data_out;

   embp_port i_embp_port (.sys_clk(sys_clk), .srst(srst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .upper_address_gpio_port(upper_address_gpio_port), .mid_address_gpio_bits(mid_address_gpio_bits),
      .pins(pins), .ext_address_oe(ext_address_oe), .ctrl_oe(ctrl_oe), .ext_data_out(ext_data_out),
      .ext_data_oe(ext_data_oe), .ext_data_pullup_en(ext_data_pullup_en), .ext_data_in(bus));
   embp_mem_model i_embp_mem_model (.sys_clk(sys_clk), .pins(pins), .bus(bus), .mem_oe(mem_oe), .mem_q(mem_q));

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one access; d is write data, or the expected read data
   task automatic acc(input logic w, input logic ps, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int k;
      int seen;
      int nrsp;
      seen = 0;
      nrsp = 0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req       <= '{write: w, prog_space: ps, addr: a, wdata: d};
      @(negedge sys_clk);
      for (k = 0; k < 20 && req_ready !== 1'b1; k++)
         @(negedge sys_clk);
      `CHK("ready", 1'b1, req_ready)
      @(posedge sys_clk);
      req_valid <= 1'b0;
      for (k = 1; k <= 6; k++)
      begin
         @(negedge sys_clk);
         if (pins.rd_n === 1'b0 || pins.wr_n === 1'b0)
         begin
            seen++;
            `CHK("addr", a, pins.addr)
            `CHK("prog_sel_n", ~ps, pins.prog_sel_n)
            `CHK("data_sel_n", ps, pins.data_sel_n)
            `CHK("strobes", w ? 2'b10 : 2'b01, {pins.rd_n, pins.wr_n})
            `CHK("data_oe", w ? 16'hFFFF : 16'h0000, ext_data_oe)
            `CHK("addr_oe", exp_aoe, ext_address_oe)
            `CHK("ctrl_oe", 1'b1, ctrl_oe)
            if (w)
               `CHK("wdata", d, ext_data_out)
         end
         if (rsp_valid === 1'b1)
         begin
            nrsp++;
            `CHK("rsp_time", SETUP_CYC + STROBE_CYC + HOLD_CYC + 1, k)
            if (!w)
               `CHK("rdata", d, rsp_rdata)
         end
      end
      `CHK("rsp_count", 1, nrsp)
      `CHK("strobe_len", STROBE_CYC, seen)
      `CHK("idle_oe", 16'h0000, ext_data_oe)
      `CHK("idle_pullup", 1'b1, ext_data_pullup_en)
   endtask

   task automatic t_reset();
      @(negedge sys_clk);
      `CHK("rst_addr_oe", 16'h0000, ext_address_oe)
      `CHK("rst_ctrl_oe", 1'b0, ctrl_oe)
      `CHK("rst_data_oe", 16'h0000, ext_data_oe)
      `CHK("rst_ready", 1'b0, req_ready)
      `CHK("rst_pins", 4'hF, {pins.prog_sel_n, pins.data_sel_n, pins.rd_n, pins.wr_n})
   endtask

   // reset cut into a write strobe: bus released, port usable again
   task automatic t_midrst();
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req       <= '{write: 1'b1, prog_space: 1'b0, addr: 16'h0040, wdata: 16'h5A5A};
      @(posedge sys_clk);
      req_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b1;
      @(negedge sys_clk);
      `CHK("mid_wr_n", 1'b0, pins.wr_n)
      t_reset();
      @(posedge sys_clk);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      acc(1'b1, 1'b0, 16'h0041, 16'h0F0F);
      acc(1'b0, 1'b0, 16'h0041, 16'h0F0F);
   endtask

   // same low byte in both spaces, back to back, boundary addresses
   task automatic t_spaces();
      acc(1'b1, 1'b1, 16'hFFFF, 16'h1234);
      acc(1'b1, 1'b0, 16'h00FF, 16'hA5C3);
      acc(1'b0, 1'b1, 16'hFFFF, 16'h1234);
      acc(1'b0, 1'b0, 16'h00FF, 16'hA5C3);
      acc(1'b1, 1'b0, 16'h0000, 16'h0000);
      acc(1'b0, 1'b0, 16'h0000, 16'h0000);
   endtask

   // pins handed to gpio lose their address drivers
   task automatic t_gpio();
      @(posedge sys_clk);
      upper_address_gpio_port <= 8'hF0;
      mid_address_gpio_bits   <= 2'h1;
      exp_aoe = {~8'hF0, ~2'h1, 6'h3F};
      acc(1'b0, 1'b1, 16'h5AFF, 16'h1234);
   endtask

   initial
   begin
      repeat (4) @(posedge sys_clk);
      t_reset();
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      t_spaces();
      t_midrst();
      t_gpio();
      stop_test();
   end

   initial
   begin
      #50000;
      errors++;
      stop_test();
   end
endmodule
